/* File: boot_map_pkg.sv */
// constants and types shared by the boot mode selector and memory map
// assumes a single 125 MHz system clock
package boot_map_pkg;

    // ------------------------------------------------------------
    // clock and serial link timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int BOOT_BAUD = 9600;
    localparam int BAUD_DIV_DEFAULT = CLK_HZ / BOOT_BAUD;
    localparam int DATA_BITS = 8;

    // ------------------------------------------------------------
    // boot link bytes
    // ------------------------------------------------------------
    localparam logic [7:0] MATCH_BYTE = 8'h5a;
    localparam logic [7:0] CMD_FLASH_WRITE = 8'h30;
    localparam logic [7:0] CMD_RAM_LOAD = 8'h60;
    localparam logic [7:0] CMD_FLASH_SUM = 8'h90;
    localparam logic [7:0] CMD_PRODUCT_ID = 8'hc0;

    // ------------------------------------------------------------
    // memory map
    // ------------------------------------------------------------
    localparam logic [15:0] FLASH_BASE = 16'hc000;
    localparam logic [15:0] FLASH_LAST = 16'hffff;
    localparam logic [15:0] BOOT_BASE = 16'hf800;
    localparam logic [15:0] BOOT_LAST = 16'hffff;
    localparam logic [15:0] RAM_BASE = 16'h0040;
    localparam logic [15:0] RAM_LAST = 16'h023f;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ------------------------------------------------------------
    // resonator frequencies allowed in boot mode, in MHz
    // ------------------------------------------------------------
    localparam logic [7:0] FREQ_2 = 8'h02;
    localparam logic [7:0] FREQ_4 = 8'h04;
    localparam logic [7:0] FREQ_8 = 8'h08;
    localparam logic [7:0] FREQ_16 = 8'h10;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic flash;
        logic boot_rom;
        logic ram;
    } map_sel_type;

    typedef struct packed {
        logic test;
        logic rx;
        logic tx;
    } straps_type;

    typedef enum logic [4:0] {
        OP_NONE = 5'b00001,
        OP_FLASH_WRITE = 5'b00010,
        OP_RAM_LOAD = 5'b00100,
        OP_FLASH_SUM = 5'b01000,
        OP_PRODUCT_ID = 5'b10000
    } op_type;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_type;

    typedef enum logic [2:0] {
        LK_WAIT = 3'b001,
        LK_READY = 3'b010,
        LK_RUN = 3'b100
    } link_state_type;

endpackage

/* File: boot_mode_select_and_map.sv */
// boot mode selection from straps, memory map decode, boot serial link
// assumes pins arrive asynchronously; the pad resolves two-way pins from the enables
`timescale 1ns/1ps
module boot_mode_select_and_map
    import boot_map_pkg::*;
#(
    parameter int BAUD_DIV = BAUD_DIV_DEFAULT
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic test_strap_pin,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    input wire logic internal_error_reset,
    input wire logic port1_bit0_pin,
    input wire logic port1_bit1_pin_in,
    output logic port1_bit1_pin_out,
    output logic port1_bit1_pin_oe_n,
    input wire logic [7:0] resonator_mhz,
    input wire logic [15:0] cpu_addr,
    output map_sel_type mem_sel,
    output logic [13:0] flash_index,
    output logic [10:0] boot_rom_index,
    output logic [8:0] ram_index,
    output logic app_mode_run,
    output logic boot_program_run,
    output logic boot_clock_bad,
    output logic link_matched,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output op_type op_code,
    output logic op_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_start,
    output logic tx_busy
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // reset pin seen as held until the real level has passed both flops
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end
        else
        begin
            pin_meta <= {port1_bit1_pin_in, port1_bit0_pin, test_strap_pin, reset_pin_in};
            pin_sync <= pin_meta;
        end
    end

    wire logic reset_held = ~pin_sync[0];
    wire straps_type straps_now = '{test: pin_sync[1], rx: pin_sync[2], tx: pin_sync[3]};

    // ------------------------------------------------------------
    // mode latch and run qualifiers
    // ------------------------------------------------------------
    logic boot_mode;

    function automatic logic freq_ok(input logic [7:0] mhz);
        freq_ok = (mhz == FREQ_2) || (mhz == FREQ_4) || (mhz == FREQ_8) || (mhz == FREQ_16);
    endfunction

    // tracks straps only while reset is held, so the value frozen is the last one before release
    wire logic next_boot_mode = straps_now.test & straps_now.rx & straps_now.tx;
    wire logic clock_ok = freq_ok(resonator_mhz);
    wire logic next_boot_run = boot_mode & ~reset_held & clock_ok;
    wire logic next_app_run = ~boot_mode & ~reset_held;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            boot_mode <= 1'b0;
        else if (reset_held)
            boot_mode <= next_boot_mode;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            boot_program_run <= 1'b0;
            app_mode_run <= 1'b0;
            boot_clock_bad <= 1'b0;
            reset_pin_out <= 1'b0;
            reset_pin_oe_n <= 1'b1;
        end
        else
        begin
            boot_program_run <= next_boot_run;
            app_mode_run <= next_app_run;
            boot_clock_bad <= boot_mode & ~reset_held & ~clock_ok;
            reset_pin_out <= 1'b0;
            reset_pin_oe_n <= ~internal_error_reset;
        end
    end

    // ------------------------------------------------------------
    // memory map decode
    // ------------------------------------------------------------
    wire logic in_boot_range = (cpu_addr >= BOOT_BASE) && (cpu_addr <= BOOT_LAST);
    wire logic in_flash_range = (cpu_addr >= FLASH_BASE) && (cpu_addr <= FLASH_LAST);
    wire logic in_ram_range = (cpu_addr >= RAM_BASE) && (cpu_addr <= RAM_LAST);
    wire logic next_boot_sel = boot_mode & in_boot_range;
    wire logic next_flash_sel = in_flash_range & ~next_boot_sel;
    wire logic [15:0] ram_offset = cpu_addr - RAM_BASE;
    wire map_sel_type next_sel = '{flash: next_flash_sel, boot_rom: next_boot_sel,
                                   ram: in_ram_range};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mem_sel <= '0;
            flash_index <= '0;
            boot_rom_index <= '0;
            ram_index <= '0;
        end
        else
        begin
            mem_sel <= next_sel;
            flash_index <= cpu_addr[13:0];
            boot_rom_index <= cpu_addr[10:0];
            ram_index <= ram_offset[8:0];
        end
    end

    // ------------------------------------------------------------
    // serial receiver, 8n1
    // ------------------------------------------------------------
    localparam logic [15:0] BIT_LAST = 16'(BAUD_DIV - 1);
    localparam logic [15:0] HALF_LAST = 16'(BAUD_DIV / 2 - 1);
    localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

    rx_state_type rx_state;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_done;
    logic rx_stop_ok;

    // the line idles high outside boot mode so no frame can start
    wire logic rx_line = boot_program_run ? pin_sync[2] : 1'b1;
    wire logic rx_tick = (rx_cnt == BIT_LAST);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_state <= RX_IDLE;
            rx_cnt <= '0;
            rx_bit <= '0;
            rx_shift <= '0;
            rx_done <= 1'b0;
            rx_stop_ok <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            rx_cnt <= rx_cnt + 16'h0001;
            case (rx_state)
                RX_IDLE:
                begin
                    rx_cnt <= '0;
                    if (!rx_line)
                        rx_state <= RX_START;
                end
                RX_START:
                    if (rx_cnt == HALF_LAST)
                    begin
                        rx_cnt <= '0;
                        rx_bit <= '0;
                        rx_state <= rx_line ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (rx_tick)
                    begin
                        rx_cnt <= '0;
                        rx_shift <= {rx_line, rx_shift[7:1]};
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == LAST_BIT)
                            rx_state <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_tick)
                    begin
                        rx_done <= 1'b1;
                        rx_stop_ok <= rx_line;
                        rx_state <= RX_IDLE;
                    end
                default:
                    rx_state <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // match, echo and command decode
    // ------------------------------------------------------------
    link_state_type link_state;
    logic echo_req;

    wire logic rx_good = rx_done & rx_stop_ok;
    wire logic match_seen = rx_good && (rx_shift == MATCH_BYTE);
    wire op_type next_op = (rx_shift == CMD_FLASH_WRITE) ? OP_FLASH_WRITE :
                           (rx_shift == CMD_RAM_LOAD) ? OP_RAM_LOAD :
                           (rx_shift == CMD_FLASH_SUM) ? OP_FLASH_SUM :
                           (rx_shift == CMD_PRODUCT_ID) ? OP_PRODUCT_ID : OP_NONE;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link_state <= LK_WAIT;
            echo_req <= 1'b0;
            link_matched <= 1'b0;
            rx_data <= '0;
            rx_valid <= 1'b0;
            op_code <= OP_NONE;
            op_valid <= 1'b0;
        end
        else
        begin
            echo_req <= 1'b0;
            rx_valid <= 1'b0;
            op_valid <= 1'b0;
            if (!boot_program_run)
            begin
                link_state <= LK_WAIT;
                link_matched <= 1'b0;
                op_code <= OP_NONE;
            end
            else
                case (link_state)
                    LK_WAIT:
                        if (match_seen)
                        begin
                            echo_req <= 1'b1;
                            link_matched <= 1'b1;
                            link_state <= LK_READY;
                        end
                    LK_READY:
                        if (rx_good)
                        begin
                            rx_data <= rx_shift;
                            rx_valid <= 1'b1;
                            op_code <= next_op;
                            op_valid <= 1'b1;
                            link_state <= LK_RUN;
                        end
                    LK_RUN:
                        if (rx_good)
                        begin
                            rx_data <= rx_shift;
                            rx_valid <= 1'b1;
                        end
                    default:
                        link_state <= LK_WAIT;
                endcase
        end
    end

    // ------------------------------------------------------------
    // serial transmitter, 8n1
    // ------------------------------------------------------------
    logic [8:0] tx_shift;
    logic [3:0] tx_bits;
    logic [15:0] tx_cnt;
    logic tx_line;

    wire logic user_tx_ok = tx_start & (link_state != LK_WAIT) & boot_program_run;
    wire logic tx_load = ~tx_busy & (echo_req | user_tx_ok);
    wire logic [7:0] tx_byte = echo_req ? MATCH_BYTE : tx_data;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_busy <= 1'b0;
            tx_line <= 1'b1;
            tx_shift <= '1;
            tx_bits <= '0;
            tx_cnt <= '0;
        end
        else if (tx_load)
        begin
            tx_busy <= 1'b1;
            tx_line <= 1'b0;
            tx_shift <= {1'b1, tx_byte};
            tx_bits <= 4'(DATA_BITS + 1);
            tx_cnt <= '0;
        end
        else if (tx_busy)
        begin
            tx_cnt <= tx_cnt + 16'h0001;
            if (tx_cnt == BIT_LAST)
            begin
                tx_cnt <= '0;
                if (tx_bits == 4'h0)
                    tx_busy <= 1'b0;
                else
                begin
                    tx_line <= tx_shift[0];
                    tx_shift <= {1'b1, tx_shift[8:1]};
                    tx_bits <= tx_bits - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            port1_bit1_pin_out <= 1'b1;
            port1_bit1_pin_oe_n <= 1'b1;
        end
        else
        begin
            port1_bit1_pin_out <= tx_line;
            port1_bit1_pin_oe_n <= ~next_boot_run;
        end
    end

endmodule

/* File: boot_mode_select_and_map_chk.sv */
// assertions on the ports of the boot mode selector and map
// assumes one clock, clk, and the active-high asynchronous sys_rst
`timescale 1ns/1ps
module boot_mode_select_and_map_chk
    import boot_map_pkg::*;
#(
    parameter int BAUD_DIV = BAUD_DIV_DEFAULT
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic internal_error_reset,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe_n,
    input wire logic port1_bit1_pin_out,
    input wire logic port1_bit1_pin_oe_n,
    input wire logic [15:0] cpu_addr,
    input wire map_sel_type mem_sel,
    input wire logic [13:0] flash_index,
    input wire logic [10:0] boot_rom_index,
    input wire logic [8:0] ram_index,
    input wire logic app_mode_run,
    input wire logic boot_program_run,
    input wire logic boot_clock_bad,
    input wire logic link_matched,
    input wire logic op_valid,
    input wire logic tx_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_app_no_boot:
        assert property (app_mode_run && $past(app_mode_run) |-> !mem_sel.boot_rom)
        else $error("boot memory selected in application mode");
    a_flash_map:
        assert property (app_mode_run && $past(app_mode_run) && $past(cpu_addr[15:14]) == 2'b11
            |-> mem_sel.flash && flash_index == $past(cpu_addr[13:0]))
        else $error("flash decode wrong in application mode");
    a_boot_map:
        assert property (boot_program_run && $past(boot_program_run)
            && $past(cpu_addr[15:11]) == 5'h1f
            |-> mem_sel.boot_rom && !mem_sel.flash && boot_rom_index == $past(cpu_addr[10:0]))
        else $error("boot memory decode wrong in boot mode");
    a_ram_map:
        assert property (!$past(sys_rst) && $past(cpu_addr) inside {[16'h0040:16'h023f]}
            |-> mem_sel.ram && ram_index == 9'($past(cpu_addr) - 16'h0040))
        else $error("data ram decode wrong");
    a_err_drive:
        assert property ($rose(internal_error_reset) |=> !reset_pin_oe_n && !reset_pin_out)
        else $error("reset pin not driven low on internal error");
    a_err_release:
        assert property ($fell(internal_error_reset) |=> reset_pin_oe_n)
        else $error("reset pin not released after internal error");
    a_tx_quiet:
        assert property (!boot_program_run && !$past(boot_program_run) |-> port1_bit1_pin_oe_n)
        else $error("transmit pin driven outside boot program");
    a_bad_clock:
        assert property (boot_clock_bad |-> !boot_program_run && !app_mode_run)
        else $error("program runs with unsupported resonator");
    a_start_bit:
        assert property ($rose(tx_busy) |=> !port1_bit1_pin_out [*4])
        else $error("start bit missing or short");
    a_op_after_match:
        assert property (op_valid |-> link_matched ##1 !op_valid)
        else $error("command pulse without match or too long");
    a_match_in_boot:
        assert property ($rose(link_matched) |-> boot_program_run)
        else $error("match seen outside boot program");
endmodule

bind boot_mode_select_and_map boot_mode_select_and_map_chk #(.BAUD_DIV(BAUD_DIV)) u_chk (
    .clk, .sys_rst, .internal_error_reset, .reset_pin_out, .reset_pin_oe_n,
    .port1_bit1_pin_out, .port1_bit1_pin_oe_n, .cpu_addr, .mem_sel, .flash_index,
    .boot_rom_index, .ram_index, .app_mode_run, .boot_program_run, .boot_clock_bad,
    .link_matched, .op_valid, .tx_busy
);

/* File: prog_ctrl_model.sv */
// external programming controller on the boot serial link
// assumes bit time of BIT clocks; caller runs send_byte from clk domain
`timescale 1ns/1ps
module prog_ctrl_model #(
    parameter int BIT = 16
)
(
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] got [$];

    initial rxd = 1'b1;

    // stop level 0 gives a framing error on purpose
    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        @(posedge clk);
        for (int i = 0; i < 10; i++)
        begin
            rxd <= f[i];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge clk);
    endtask

    // byte catcher on the transmit line, mid-bit sampling
    always
    begin
        logic [7:0] b;
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk);
            b[i] = txd;
        end
        repeat (BIT) @(posedge clk);
        if (txd === 1'b1)
            got.push_back(b);
    end
endmodule

/* File: tb_boot_mode_select_and_map.sv */
// self-checking bench for the boot mode selector and map
// assumes prog_ctrl_model and the bound checker are compiled alongside
`timescale 1ns/1ps
module tb_boot_mode_select_and_map;
    import boot_map_pkg::*;
`define CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("[FAIL] %s expected %h seen %h", what, exp, got); \
        end \
    end
    int n_errors = 0;
    int checked = 0;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic test_strap_pin = 1'b0;
    logic strap_rx = 1'b1;
    logic strap_tx = 1'b1;
    logic rst_pin_drv = 1'b0;
    logic internal_error_reset = 1'b0;
    logic [7:0] resonator_mhz = 8'h08;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] tx_data = 8'h00;
    logic tx_start = 1'b0;
    logic reset_pin_out, reset_pin_oe_n, port1_bit1_pin_out, port1_bit1_pin_oe_n;
    logic app_mode_run, boot_program_run, boot_clock_bad, link_matched, op_valid;
    logic rx_valid, tx_busy;
    logic [7:0] rx_data, last_rx;
    logic [13:0] flash_index;
    logic [10:0] boot_rom_index;
    logic [8:0] ram_index;
    map_sel_type mem_sel;
    op_type op_code;
    op_type last_op;
    logic rst_line, p10_line, p11_line, rxd;

    always #4 clk = ~clk;
    // open-drain reset pin and pulled-up link pins
    assign rst_line = rst_pin_drv & (reset_pin_oe_n | reset_pin_out);
    assign p10_line = strap_rx & rxd;
    assign p11_line = port1_bit1_pin_oe_n ? strap_tx : port1_bit1_pin_out;
    always @(posedge clk)
    begin
        if (op_valid === 1'b1)
            last_op <= op_code;
        if (rx_valid === 1'b1)
            last_rx <= rx_data;
    end

    boot_mode_select_and_map #(.BAUD_DIV(16)) DUT (
        .clk, .sys_rst, .test_strap_pin, .reset_pin_in(rst_line), .reset_pin_out,
        .reset_pin_oe_n, .internal_error_reset, .port1_bit0_pin(p10_line),
        .port1_bit1_pin_in(p11_line), .port1_bit1_pin_out, .port1_bit1_pin_oe_n,
        .resonator_mhz, .cpu_addr, .mem_sel, .flash_index, .boot_rom_index, .ram_index,
        .app_mode_run, .boot_program_run, .boot_clock_bad, .link_matched, .rx_data,
        .rx_valid, .op_code, .op_valid, .tx_data, .tx_start, .tx_busy
    );
    prog_ctrl_model #(.BIT(16)) u_pc (.clk, .txd(p11_line), .rxd);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic pin_reset(input logic t, input logic r, input logic x, input logic [7:0] f);
        @(posedge clk);
        rst_pin_drv <= 1'b0;
        test_strap_pin <= t;
        strap_rx <= r;
        strap_tx <= x;
        resonator_mhz <= f;
        repeat (6) @(posedge clk);
        rst_pin_drv <= 1'b1;
        repeat (3) @(posedge clk);
        strap_rx <= 1'b1;
        strap_tx <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wait_tx(input int n);
        for (int k = 0; k < 400 && u_pc.got.size() < n; k++)
            @(posedge clk);
        @(negedge clk);
        `CHK("tx count", n, u_pc.got.size())
    endtask

    task automatic link_up();
        pin_reset(1'b1, 1'b1, 1'b1, 8'h10);
        u_pc.got.delete();
        u_pc.send_byte(8'h5a, 1'b1);
        wait_tx(1);
        `CHK("echo", 8'h5a, u_pc.got[0])
        `CHK("linked", 1'b1, link_matched)
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_modes();
        logic [13:0] row [8] = '{{3'b011, 8'h08, 3'b100}, {3'b101, 8'h08, 3'b100},
            {3'b110, 8'h08, 3'b100}, {3'b111, 8'h02, 3'b010}, {3'b111, 8'h04, 3'b010},
            {3'b111, 8'h08, 3'b010}, {3'b111, 8'h10, 3'b010}, {3'b111, 8'h03, 3'b001}};
        for (int i = 0; i < 8; i++)
        begin
            pin_reset(row[i][13], row[i][12], row[i][11], row[i][10:3]);
            `CHK("mode", row[i][2:0], {app_mode_run, boot_program_run, boot_clock_bad})
        end
        $display("test modes done");
    endtask

    task automatic t_decode(input logic boot);
        logic [15:0] a [8] = '{16'hc000, 16'hf7ff, 16'hf800, 16'hffff, 16'h0040, 16'h023f,
            16'h0240, 16'h003f};
        map_sel_type e;
        pin_reset(boot, 1'b1, 1'b1, 8'h08);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            cpu_addr <= a[i];
            @(posedge clk);
            @(negedge clk);
            e.boot_rom = boot && a[i] >= 16'hf800;
            e.flash = a[i] >= 16'hc000 && !e.boot_rom;
            e.ram = a[i] >= 16'h0040 && a[i] <= 16'h023f;
            `CHK("map", e, mem_sel)
            if (e.boot_rom) `CHK("rom index", a[i][10:0], boot_rom_index)
            if (e.flash) `CHK("flash index", a[i][13:0], flash_index)
            if (e.ram) `CHK("ram index", 9'(a[i] - 16'h0040), ram_index)
        end
        $display("test decode done");
    endtask

    task automatic t_link();
        logic [7:0] c [5] = '{8'h30, 8'h60, 8'h90, 8'hc0, 8'h11};
        op_type o [5] = '{OP_FLASH_WRITE, OP_RAM_LOAD, OP_FLASH_SUM, OP_PRODUCT_ID, OP_NONE};
        pin_reset(1'b1, 1'b1, 1'b1, 8'h08);
        u_pc.got.delete();
        u_pc.send_byte(8'h33, 1'b1);
        u_pc.send_byte(8'h5a, 1'b0);
        repeat (300) @(posedge clk);
        @(negedge clk);
        `CHK("silent", 0, u_pc.got.size())
        `CHK("unlinked", 1'b0, link_matched)
        for (int i = 0; i < 5; i++)
        begin
            link_up();
            u_pc.send_byte(c[i], 1'b1);
            repeat (20) @(posedge clk);
            @(negedge clk);
            `CHK("command", o[i], last_op)
            `CHK("command byte", c[i], last_rx)
        end
        u_pc.send_byte(ERASED_BYTE, 1'b1);
        repeat (20) @(posedge clk);
        @(negedge clk);
        `CHK("fill byte", 8'hff, last_rx)
        $display("test link done");
    endtask

    task automatic t_send_and_err();
        u_pc.got.delete();
        @(posedge clk);
        tx_data <= 8'ha5;
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        test_strap_pin <= 1'b0;
        @(negedge clk);
        `CHK("busy", 1'b1, tx_busy)
        wait_tx(1);
        `CHK("sent byte", 8'ha5, u_pc.got[0])
        `CHK("mode held", 1'b1, boot_program_run)
        @(posedge clk);
        internal_error_reset <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        `CHK("pin drive", 2'b00, {reset_pin_oe_n, reset_pin_out})
        `CHK("held", 1'b0, boot_program_run)
        @(posedge clk);
        internal_error_reset <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        `CHK("pin free", 1'b1, reset_pin_oe_n)
        `CHK("app after", 1'b1, app_mode_run)
        `CHK("tx idle", 1'b0, tx_busy)
        $display("test send and error reset done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_modes();
        t_decode(1'b0);
        t_decode(1'b1);
        t_link();
        t_send_and_err();
        wrap_up();
    end

    initial
    begin
        #400000;
        n_errors++;
        wrap_up();
    end
endmodule
